/* File: iwrs_slave.sv */
// two-wire slave front end with pointer, word writes and block reads
// Overview of operation
// - slave only, fast and high-speed rates
// - every byte shifted msb first
// - sda edge while scl high: start/stop
// - take address byte, ack on match
// - strap picks one of four addresses
// - first write byte loads the pointer
// - pointer-only write changes no register
// - reads use last written pointer, retained outside the window
// - word read sends upper byte first
// - msb-only read restarts at msb next
// - msb-only read costs nothing, changes nothing
// - commit at second data byte ack only
// - block reads only in window 80h-88h
// - window pointers mirror registers 00h-08h
// - never load the bus during reset
// - window auto-increments, wraps after 88h
// - stuck-low timeout releases sda and returns to idle
// - master code: no ack, high-speed until stop
module iwrs_slave #(
  parameter int TIMEOUT_CYCLES = iwrs_pkg::TMO_CYCLES // shorten in simulation
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl, // bus clock pin, also the link clock
  input wire logic i_sda, // bus data pin level
  input wire logic [1:0] i_addr_sel, // strap connection code
  input wire logic [15:0] i_rd_data, // word at o_rd_addr, same clock
  output logic o_sda_out, // always low when enabled
  output logic o_sda_oe, // high while pulling sda low
  output logic [7:0] o_rd_addr, // register to read
  output iwrs_pkg::iwrs_wr_t o_wr, // one-cycle write request
  output logic o_hs_mode // high-speed mode active
);
  import iwrs_pkg::*;

  // complete state of the engine
  typedef struct packed {
    iwrs_state_t st; // protocol state
    iwrs_state_t ack_to; // state after the ack slot
    logic [1:0] scl_sy; // [0] first flop, [1] second
    logic [1:0] sda_sy; // [0] first flop, [1] second
    logic scl_d; // delayed copy for edges
    logic sda_d; // delayed copy for edges
    logic [2:0] tog_sy; // bit toggle synchroniser plus edge stage
    logic [1:0] asel_s1; // strap first flop
    logic [1:0] asel_s2; // strap second flop
    logic [7:0] sh; // shift register
    logic [3:0] bitcnt; // bits seen in the byte
    logic ack_seen; // ack clock has risen
    logic nack; // master left sda high
    logic send_lsb; // byte in flight is the low byte
    logic [7:0] ptr; // pointer register
    logic [7:0] msb; // held upper data byte
    logic [15:0] txw; // word being transmitted
    logic sda_oe; // drive sda low
    logic hs; // high-speed mode
    logic [TMO_W-1:0] tmo; // stuck-low counter
    iwrs_wr_t wr; // write request
    logic [7:0] rd_addr; // mirrored read address
  } iwrs_core_t;

  iwrs_core_t r_reg;
  iwrs_core_t r_next;

  // captured bit from the link domain
  iwrs_bit_t link_bit;

  // decoded bus events
  logic scl_lvl;
  logic sda_lvl;
  logic start_evt;
  logic stop_evt;
  logic scl_fall;
  logic bit_evt;
  logic [6:0] my_addr;

  // pointer in the block-read window
  function automatic logic in_window(input logic [7:0] p);
    in_window = (p >= WIN_BASE) && (p <= WIN_LAST);
  endfunction

  // window pointers address the result registers underneath
  function automatic logic [7:0] map_ptr(input logic [7:0] p);
    map_ptr = in_window(p) ? (p - WIN_BASE) : p;
  endfunction

  // next pointer after a word went out
  function automatic logic [7:0] step_ptr(input logic [7:0] p);
    if (p == WIN_LAST) begin
      step_ptr = WIN_BASE;
    end else if (in_window(p)) begin
      step_ptr = p + 8'h01;
    end else begin
      step_ptr = p;
    end
  endfunction

  // strap decode, one of four fixed addresses
  function automatic logic [6:0] strap_addr(input logic [1:0] s);
    unique case (s)
      ASEL_GND: strap_addr = SLV_ADDR_BASE;
      ASEL_VDD: strap_addr = SLV_ADDR_BASE | 7'h01;
      ASEL_SDA: strap_addr = SLV_ADDR_BASE | 7'h02;
      ASEL_SCL: strap_addr = SLV_ADDR_BASE | 7'h03;
    endcase
  endfunction

  // link-domain sampler, clocked by scl itself
  iwrs_bit_sampler u_sampler (
    .i_scl(i_scl),
    .i_reset(i_reset),
    .i_sda(i_sda),
    .o_bit(link_bit)
  );

  // edges only look at second flops and later
  always_comb begin
    scl_lvl = r_reg.scl_sy[1];
    sda_lvl = r_reg.sda_sy[1];
    start_evt = r_reg.scl_d & scl_lvl & r_reg.sda_d & ~sda_lvl;
    stop_evt = r_reg.scl_d & scl_lvl & ~r_reg.sda_d & sda_lvl;
    scl_fall = r_reg.scl_d & ~scl_lvl;
    bit_evt = r_reg.tog_sy[2] ^ r_reg.tog_sy[1];
    my_addr = strap_addr(r_reg.asel_s2);
  end

  // protocol engine
  always_comb begin
    r_next = r_reg;
    r_next.wr.en = 1'b0;
    // pin and crossing synchronisers
    r_next.scl_sy = {r_reg.scl_sy[0], i_scl};
    r_next.sda_sy = {r_reg.sda_sy[0], i_sda};
    r_next.scl_d = r_reg.scl_sy[1];
    r_next.sda_d = r_reg.sda_sy[1];
    r_next.tog_sy = {r_reg.tog_sy[1:0], link_bit.tog};
    r_next.asel_s1 = i_addr_sel;
    r_next.asel_s2 = r_reg.asel_s1;
    // stuck-low watch only inside a transaction
    if ((r_reg.st != ST_IDLE) && (~scl_lvl || ~sda_lvl)) begin
      r_next.tmo = r_reg.tmo + {{(TMO_W-1){1'b0}}, 1'b1};
    end else begin
      r_next.tmo = '0;
    end
    if (r_reg.tmo >= TMO_W'(TIMEOUT_CYCLES - 1)) begin
      // give the bus back and wait for a fresh start
      r_next.st = ST_IDLE;
      r_next.sda_oe = 1'b0;
      r_next.tmo = '0;
    end else if (stop_evt) begin
      // stop ends everything, including high-speed mode
      r_next.st = ST_IDLE;
      r_next.sda_oe = 1'b0;
      r_next.hs = 1'b0;
    end else if (start_evt) begin
      // start or repeated start: a new address byte follows
      r_next.st = ST_ADDR;
      r_next.bitcnt = '0;
      r_next.sda_oe = 1'b0;
    end else begin
      unique case (r_reg.st)
        ST_ADDR, ST_PTR, ST_WMSB, ST_WLSB: begin
          // receive a byte, msb first
          if (bit_evt && (r_reg.bitcnt < BYTE_BITS)) begin
            r_next.sh = {r_reg.sh[6:0], link_bit.bit_val};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          if (scl_fall && (r_reg.bitcnt == BYTE_BITS)) begin
            r_next.bitcnt = '0;
            r_next.ack_seen = 1'b0;
            r_next.st = ST_ACK;
            r_next.sda_oe = 1'b1;
            unique case (r_reg.st)
              ST_ADDR: begin
                if (r_reg.sh[7:3] == HS_MCODE) begin
                  // master code is never acknowledged
                  r_next.hs = 1'b1;
                  r_next.sda_oe = 1'b0;
                  r_next.st = ST_IGNORE;
                end else if (r_reg.sh[7:1] != my_addr) begin
                  // not ours: keep sda released
                  r_next.sda_oe = 1'b0;
                  r_next.st = ST_IGNORE;
                end else if (r_reg.sh[0]) begin
                  // read: first byte is always the upper one
                  r_next.ack_to = ST_TX;
                  r_next.send_lsb = 1'b0;
                end else begin
                  r_next.ack_to = ST_PTR;
                end
              end
              ST_PTR: begin
                // first write byte is the pointer
                r_next.ptr = r_reg.sh;
                r_next.rd_addr = map_ptr(r_reg.sh);
                r_next.ack_to = ST_WMSB;
              end
              ST_WMSB: begin
                // hold upper byte; nothing is written yet
                r_next.msb = r_reg.sh;
                r_next.ack_to = ST_WLSB;
              end
              default: begin
                // second data byte: commit the word at its ack
                r_next.wr.en = 1'b1;
                r_next.wr.addr = map_ptr(r_reg.ptr);
                r_next.wr.data = {r_reg.msb, r_reg.sh};
                r_next.ack_to = ST_WMSB;
              end
            endcase
          end
        end
        ST_ACK: begin
          // hold sda low across the ninth clock
          if (bit_evt) begin
            r_next.ack_seen = 1'b1;
          end
          if (scl_fall && r_reg.ack_seen) begin
            r_next.sda_oe = 1'b0;
            r_next.st = r_reg.ack_to;
            if (r_reg.ack_to == ST_TX) begin
              // load the word and put its top bit out
              r_next.txw = i_rd_data;
              r_next.sh = i_rd_data[15:8];
              r_next.sda_oe = ~i_rd_data[15];
              r_next.bitcnt = '0;
            end
          end
        end
        ST_TX: begin
          // drive on scl low only, count bits on rises
          if (bit_evt) begin
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          if (scl_fall) begin
            if (r_reg.bitcnt == BYTE_BITS) begin
              r_next.sda_oe = 1'b0;
              r_next.ack_seen = 1'b0;
              r_next.st = ST_TXACK;
            end else begin
              r_next.sh = {r_reg.sh[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.sh[6];
            end
          end
        end
        ST_TXACK: begin
          // sample the master's answer; step pointer after a low byte
          if (bit_evt) begin
            r_next.ack_seen = 1'b1;
            r_next.nack = link_bit.bit_val;
            if (r_reg.send_lsb) begin
              // stepping here gives the read port time before the fall
              r_next.ptr = step_ptr(r_reg.ptr);
              r_next.rd_addr = map_ptr(step_ptr(r_reg.ptr));
            end
          end
          if (scl_fall && r_reg.ack_seen) begin
            r_next.bitcnt = '0;
            if (r_reg.nack) begin
              // read over, pointer stays as is
              r_next.st = ST_IGNORE;
            end else if (r_reg.send_lsb) begin
              // next word, upper byte first
              r_next.txw = i_rd_data;
              r_next.sh = i_rd_data[15:8];
              r_next.sda_oe = ~i_rd_data[15];
              r_next.send_lsb = 1'b0;
              r_next.st = ST_TX;
            end else begin
              // low byte of the same word
              r_next.sh = r_reg.txw[7:0];
              r_next.sda_oe = ~r_reg.txw[7];
              r_next.send_lsb = 1'b1;
              r_next.st = ST_TX;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          // released, waiting for start or stop
          r_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // single register stage for all engine state
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.ack_to <= ST_IDLE;
      r_reg.scl_sy <= 2'h3; // idle bus reads high
      r_reg.sda_sy <= 2'h3;
      r_reg.scl_d <= 1'b1;
      r_reg.sda_d <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs: sda only ever pulled low, scl never driven
  assign o_sda_out = 1'b0;
  assign o_sda_oe = r_reg.sda_oe;
  assign o_rd_addr = r_reg.rd_addr;
  assign o_wr = r_reg.wr;
  assign o_hs_mode = r_reg.hs;

endmodule

/* File: iwrs_pkg.sv */
// shared types and constants for the two-wire word register slave
package iwrs_pkg;

  // clock and timing figures
  localparam int CLK_PERIOD_PS = 4000; // 250 mhz system clock
  localparam real TMO_MS = 17.5; // bus stuck-low timeout
  localparam int TMO_CYCLES = int'(TMO_MS * 1.0e9 / CLK_PERIOD_PS); // rounds to 4375000
  localparam int TMO_W = 23; // wide enough for the default count

  // address matching
  localparam logic [6:0] SLV_ADDR_BASE = 7'h48; // strap value adds 0..3
  localparam logic [4:0] HS_MCODE = 5'h01; // upper five bits of 0000_1xxx
  localparam logic [3:0] BYTE_BITS = 4'h8; // bits per byte on the wire

  // pointer windows
  localparam logic [7:0] WIN_BASE = 8'h80; // block-read window first pointer
  localparam logic [7:0] WIN_LAST = 8'h88; // block-read window last pointer

  // strap encodings of the address select pin
  localparam logic [1:0] ASEL_GND = 2'h0;
  localparam logic [1:0] ASEL_VDD = 2'h1;
  localparam logic [1:0] ASEL_SDA = 2'h2;
  localparam logic [1:0] ASEL_SCL = 2'h3;

  // protocol engine states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WMSB,
    ST_WLSB,
    ST_ACK,
    ST_TX,
    ST_TXACK,
    ST_IGNORE
  } iwrs_state_t;

  // register write request toward the register file
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [15:0] data;
  } iwrs_wr_t;

  // bit captured on the link clock
  typedef struct packed {
    logic bit_val;
    logic tog;
  } iwrs_bit_t;

endpackage

/* File: iwrs_bit_sampler.sv */
// scl-domain sampler: catches sda on each rising scl edge and flags it
module iwrs_bit_sampler (
  input wire logic i_scl,
  input wire logic i_reset,
  input wire logic i_sda,
  output iwrs_pkg::iwrs_bit_t o_bit
);
  import iwrs_pkg::*;

  // all state of this end
  iwrs_bit_t s_reg;
  iwrs_bit_t s_next;

  // sample sda msb first, flip the toggle once per bit
  always_comb begin
    s_next = s_reg;
    s_next.bit_val = i_sda;
    s_next.tog = ~s_reg.tog;
  end

  // scl stops between frames, so reset cannot wait for an edge here
  always_ff @(posedge i_scl or posedge i_reset) begin
    if (i_reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // value stays put until the next scl rise, far longer than the crossing
  assign o_bit = s_reg;

endmodule

/* File: iwrs_slave_asserts.sv */
// bus-side timing checker for the two-wire word register slave
module iwrs_slave_asserts #(
  parameter int TIMEOUT_CYCLES = 200
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [1:0] i_addr_sel,
  input wire logic [15:0] i_rd_data,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [7:0] o_rd_addr,
  input wire iwrs_pkg::iwrs_wr_t o_wr,
  input wire logic o_hs_mode
);
  import iwrs_pkg::*;
  int low_cnt; // cycles scl has been low, saturating
  // count stuck-low time; saturate so the helper never wraps
  always_ff @(posedge i_clk) begin
    if (i_reset || i_scl) begin
      low_cnt <= 0;
    end else if (low_cnt < TIMEOUT_CYCLES + 16) begin
      low_cnt <= low_cnt + 1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_stop;
    i_scl && $rose(i_sda);
  endsequence
  sequence s_after_fall;
    !i_scl && $past(i_scl, 6);
  endsequence
  property p_drive_low; o_sda_oe |-> !o_sda_out; endproperty
  a_drive_low: assert property (p_drive_low) else $error("sda driven high");
  property p_oe_rise; $rose(o_sda_oe) |-> s_after_fall; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("sda pull not after scl fall");
  property p_oe_scl_low; $changed(o_sda_oe) |-> !i_scl; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved with scl high");
  property p_wr_pulse; o_wr.en |=> !o_wr.en; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
  property p_wr_low; $rose(o_wr.en) |-> !i_scl; endproperty
  a_wr_low: assert property (p_wr_low) else $error("write not at ack slot");
  property p_wr_map; o_wr.en |-> !(o_wr.addr inside {[WIN_BASE:WIN_LAST]}); endproperty
  a_wr_map: assert property (p_wr_map) else $error("write address not mirrored");
  property p_rd_map; !(o_rd_addr inside {[WIN_BASE:WIN_LAST]}); endproperty
  a_rd_map: assert property (p_rd_map) else $error("read address not mirrored");
  property p_hs_stop; o_hs_mode ##0 s_stop |-> ##[1:8] !o_hs_mode; endproperty
  a_hs_stop: assert property (p_hs_stop) else $error("fast mode not restored");
  property p_hs_nack; $rose(o_hs_mode) |-> !o_sda_oe [*8]; endproperty
  a_hs_nack: assert property (p_hs_nack) else $error("master code acknowledged");
  property p_timeout; low_cnt > TIMEOUT_CYCLES + 8 |-> !o_sda_oe; endproperty
  a_timeout: assert property (p_timeout) else $error("sda held past timeout");
endmodule
bind iwrs_slave iwrs_slave_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda),
  .i_addr_sel(i_addr_sel), .i_rd_data(i_rd_data), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_rd_addr(o_rd_addr), .o_wr(o_wr), .o_hs_mode(o_hs_mode)
);

/* File: iwrs_master_model.sv */
// behavioural two-wire bus master driving scl and an open-drain sda
module iwrs_master_model (
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real Q = 12.0; // quarter bit: 48 ns scl period, keeps zero runs under the timeout
  // bus idle: both lines released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // one clock pulse: data moves mid-low, sampled mid-high
  task bit_x(input logic b, output logic s);
    #Q o_sda = b;
    #Q o_scl = 1'b1;
    #Q s = i_sda;
    #Q o_scl = 1'b0;
  endtask
  // start or repeated start; scl left low
  task start;
    #Q o_sda = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b0;
  endtask
  // stop; scl stands high after it
  task stop;
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b1;
    #Q;
  endtask
  // send one byte, report the slave's acknowledge
  task wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask
  // take one byte; nack high ends the read
  task rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, s);
  endtask
endmodule

/* File: tb_iwrs_slave.sv */
// self-checking bench for the two-wire word register slave
module tb_iwrs_slave;
  timeunit 1ns;
  timeprecision 100ps;
  import iwrs_pkg::*;
  localparam int TMO = 200; // shortened stuck-low count
  // register file pattern: word tells which register answered
  function automatic logic [15:0] w(input logic [7:0] a);
    return {a, a ^ 8'h5a};
  endfunction
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] sel = 2'h0; // strap code
  logic m_scl, m_sda, oe, sda_o, hs;
  logic [7:0] rd_addr;
  iwrs_wr_t wr, wr_last;
  int errors = 0;
  int checks = 0;
  int wr_cnt = 0; // commits seen
  wire sda = m_sda & ~oe; // pull-up wire, either side pulls low
  wire [15:0] rd_data = w(rd_addr);
  initial begin
    forever #2 clk = ~clk;
  end
  iwrs_master_model m (.o_scl(m_scl), .o_sda(m_sda), .i_sda(sda));
  iwrs_slave #(.TIMEOUT_CYCLES(TMO)) DUT (.i_clk(clk), .i_reset(reset), .i_scl(m_scl),
    .i_sda(sda), .i_addr_sel(sel), .i_rd_data(rd_data), .o_sda_out(sda_o),
    .o_sda_oe(oe), .o_rd_addr(rd_addr), .o_wr(wr), .o_hs_mode(hs));
  // record register commits
  always @(posedge clk) begin
    if (wr.en === 1'b1) begin
      wr_cnt++;
      wr_last = wr;
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // address byte with direction, acknowledge expected
  task addr(input logic rd);
    logic a;
    m.wbyte({SLV_ADDR_BASE + 7'(sel), rd}, a);
    check(a, 1'b1);
  endtask
  task put_ptr(input logic [7:0] p);
    logic a;
    m.start();
    addr(1'b0);
    m.wbyte(p, a);
    check(a, 1'b1);
  endtask
  task get_word(input logic msb_only, output logic [15:0] v);
    v = 16'h0;
    m.start();
    addr(1'b1);
    m.rbyte(msb_only, v[15:8]);
    if (!msb_only) m.rbyte(1'b1, v[7:0]);
    m.stop();
  endtask
  // each strap value; foreign addresses ignored
  task t_addr;
    logic a;
    logic [15:0] v;
    for (int s = 0; s < 4; s++) begin
      @(negedge clk) sel = 2'(s);
      repeat (8) @(negedge clk);
      put_ptr(8'h01);
      m.stop();
      m.start();
      m.wbyte({SLV_ADDR_BASE + 7'(sel + 2'h1), 1'b0}, a);
      check(a, 1'b0);
      m.wbyte(8'h03, a);
      check(a, 1'b0);
      m.stop();
    end
    get_word(1'b0, v);
    check(v, w(8'h01));
  endtask
  task t_ptr;
    logic [15:0] v;
    int n;
    n = wr_cnt;
    put_ptr(8'h03);
    m.stop();
    for (int k = 0; k < 2; k++) begin
      get_word(1'b0, v);
      check(v, w(8'h03));
    end
    check(16'(wr_cnt - n), 16'h0);
    check(16'(rd_addr), 16'h03);
  endtask
  // whole word commits; lone msb is dropped
  task t_word;
    logic a;
    int n;
    n = wr_cnt;
    put_ptr(8'h05);
    m.wbyte(8'ha5, a);
    m.wbyte(8'h3c, a);
    m.stop();
    check(16'(wr_cnt - n), 16'h1);
    check(wr_last.data, 16'ha53c);
    check(16'(wr_last.addr), 16'h05);
    put_ptr(8'h86);
    m.wbyte(8'h77, a);
    m.stop();
    check(16'(wr_cnt - n), 16'h1);
  endtask
  task t_short;
    logic [15:0] v, e;
    e = w(8'h02);
    put_ptr(8'h02);
    m.stop();
    get_word(1'b1, v);
    check(v[15:8], e[15:8]);
    get_word(1'b0, v);
    check(v, e);
  endtask
  // window steps and wraps; plain pointer repeats
  task t_block;
    logic [15:0] v;
    for (int p = 0; p < 2; p++) begin
      put_ptr(p ? 8'h02 : WIN_BASE);
      m.start();
      addr(1'b1);
      for (int k = 0; k < 10; k++) begin
        m.rbyte(1'b0, v[15:8]);
        m.rbyte(k == 9, v[7:0]);
        check(v, w(p ? 8'h02 : 8'(k % 9)));
      end
      m.stop();
    end
  endtask
  task t_hs;
    logic a;
    m.start();
    m.wbyte(8'h08, a);
    check(a, 1'b0);
    check(hs, 1'b1);
    check(sda_o, 1'b0);
    put_ptr(8'h00);
    m.stop();
    repeat (8) @(negedge clk);
    check(hs, 1'b0);
  endtask
  // scl stuck low during the ack slot
  task t_tmo;
    logic s;
    logic [15:0] v;
    logic [6:0] ad;
    ad = SLV_ADDR_BASE + 7'(sel); // address of the current strap
    m.start();
    for (int i = 6; i >= 0; i--) m.bit_x(ad[i], s);
    m.bit_x(1'b0, s); // write direction, then scl stays low
    repeat (10) @(negedge clk);
    check(oe, 1'b1);
    repeat (TMO + 20) @(negedge clk);
    check(oe, 1'b0);
    m.stop();
    get_word(1'b0, v);
    check(v, w(8'h00));
  endtask
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    t_addr();
    t_ptr();
    t_word();
    t_short();
    t_block();
    t_hs();
    t_tmo();
    give_verdict();
  end
  // cut a hang short
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
endmodule
